/* File: core/hscc_regulator.sv */
// hysteretic current regulator for one solenoid channel
`timescale 1ns/100ps
// Notes on behaviour
// - drive on until upper point, then off until lower point, repeatedly.
// - current seen as sense resistor voltage through two comparators.
// - upper and lower points sit symmetrically about the average point, unless one is clamped at an end of the code range.
// - average point is command over 1024 times 1230 mV full scale.
// - hysteresis 40 to 110 mVpp in 10 mVpp steps, eight codes.
// - codes 0..5 give offsets 17, 21, 25, 29, 33, 37 counts.
// - codes 6 and 7 give offsets 42 and 46 counts.
// - slew code 0 or 1 blanks comparators about 5 us per switch.
// - slew code 2 or 3 blanks comparators about 15 us per switch.
// - command 14D gives 400 mV, command 340 gives 1000 mV.
// - no fixed frequency or duty; switching follows comparator events only.
// - dither offset is added to the command before points are computed.
// - overtemperature forces drive off, sets fault; restart after it clears.
// - thermal fault stays latched until reported to the host.
module hscc_regulator
	import hscc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [CMD_W-1:0]  avg_cmd,
	input  wire logic [HYST_W-1:0] hysteresis_code,
	input  wire logic [SLEW_W-1:0] slew_code,
	input  wire logic signed [DITH_W-1:0] dither_offset,
	input  wire logic              above_upper_pin,
	input  wire logic              below_lower_pin,
	input  wire logic              overtemp_pin,
	input  wire logic              fault_reported,
	output hscc_points_t           switch_points,
	output logic                   lowside_drive_pin,
	output logic                   thermal_fault,
	output logic                   blanking
);
	typedef enum logic [1:0] {HSCC_OFF, HSCC_ON, HSCC_TRIP} hscc_state_t;

	hscc_state_t          state_q;
	logic [BLANK_W-1:0]   blank_q;
	logic                 above_s;
	logic                 below_s;
	logic                 ot_s;
	logic                 fault_q;
	logic [CMD_W-1:0]     avg_eff;
	logic [5:0]           hyst_cnt;
	hscc_points_t         points_d;
	logic                 switch_now;

	function automatic logic [5:0] hyst_lookup(input logic [HYST_W-1:0] c);
		case (c)
			3'h0: hyst_lookup = HYST_CNT0;
			3'h1: hyst_lookup = HYST_CNT1;
			3'h2: hyst_lookup = HYST_CNT2;
			3'h3: hyst_lookup = HYST_CNT3;
			3'h4: hyst_lookup = HYST_CNT4;
			3'h5: hyst_lookup = HYST_CNT5;
			3'h6: hyst_lookup = HYST_CNT6;
			default: hyst_lookup = HYST_CNT7;
		endcase
	endfunction : hyst_lookup

	// clamp a signed wide value into the dac code range
	function automatic logic [CMD_W-1:0] clamp_code(
		input logic signed [DITH_W+1:0] v);
		if (v < 0)
			clamp_code = '0;
		else if (v > $signed({3'b000, CMD_MAX}))
			clamp_code = CMD_MAX;
		else
			clamp_code = v[CMD_W-1:0];
	endfunction : clamp_code

	hscc_sync u_sync_hi (.ref_clk(ref_clk), .rst(rst),
		.din(above_upper_pin), .dout(above_s));
	hscc_sync u_sync_lo (.ref_clk(ref_clk), .rst(rst),
		.din(below_lower_pin), .dout(below_s));
	hscc_sync u_sync_ot (.ref_clk(ref_clk), .rst(rst),
		.din(overtemp_pin), .dout(ot_s));

	// command is a plain fraction of full scale; dac does the scaling
	always_comb begin
		avg_eff = clamp_code($signed({3'b000, avg_cmd})
			+ $signed({dither_offset[DITH_W-1], dither_offset}));
		hyst_cnt = hyst_lookup(hysteresis_code);
		points_d.upper = clamp_code($signed({3'b000, avg_eff})
			+ $signed({7'b0, hyst_cnt}));
		points_d.lower = clamp_code($signed({3'b000, avg_eff})
			- $signed({7'b0, hyst_cnt}));
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			switch_points <= '0;
		else
			switch_points <= points_d;
	end

	assign blanking = (blank_q != '0);
	// comparator events only, no timer decides a switch
	always_comb begin
		switch_now = 1'b0;
		if (!blanking) begin
			if (state_q == HSCC_ON && above_s)
				switch_now = 1'b1;
			else if (state_q == HSCC_OFF && below_s)
				switch_now = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= HSCC_OFF;
		end else begin
			case (state_q)
				HSCC_OFF:  if (ot_s) state_q <= HSCC_TRIP;
					else if (switch_now) state_q <= HSCC_ON;
				HSCC_ON:   if (ot_s) state_q <= HSCC_TRIP;
					else if (switch_now) state_q <= HSCC_OFF;
				// stay tripped through blanking; restart is a switch too
				HSCC_TRIP: if (!ot_s && !blanking)
					state_q <= HSCC_OFF;
				default:   state_q <= HSCC_OFF;
			endcase
		end
	end

	// blank on every drive edge; trip-out also counts as a switch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			blank_q <= '0;
		end else if (switch_now || (ot_s && state_q == HSCC_ON)) begin
			blank_q <= (slew_code >= SLEW_LONG_MIN)
				? BLANK_W'(LONG_BLANK_CYC)
				: BLANK_W'(SHORT_BLANK_CYC);
		end else if (blank_q != '0) begin
			blank_q <= blank_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			lowside_drive_pin <= 1'b0;
		else
			lowside_drive_pin <= (state_q == HSCC_ON) && !ot_s;
	end

	// set wins over the report clear
	always_ff @(posedge ref_clk) begin
		if (rst)
			fault_q <= 1'b0;
		else if (ot_s)
			fault_q <= 1'b1;
		else if (fault_reported)
			fault_q <= 1'b0;
	end
	assign thermal_fault = fault_q;

	// turn-off runs in two steps: state first, pin one edge later
	sequence s_state_off;
		state_q == HSCC_OFF;
	endsequence
	sequence s_pin_low;
		!lowside_drive_pin;
	endsequence
	sequence s_state_on;
		state_q == HSCC_ON;
	endsequence

	// points follow inputs one edge later
	a_hyst_span: assert property (@(posedge ref_clk)
		disable iff (rst) hysteresis_code == 3'h6 && avg_cmd == 10'h200
		&& dither_offset == '0
		|=> switch_points.upper - switch_points.lower == 10'h054)
		else $error("hysteresis span wrong");
	a_ref_low: assert property (@(posedge ref_clk)
		disable iff (rst) hysteresis_code == 3'h0 && avg_cmd == 10'h14D
		&& dither_offset == 11'h003
		|=> switch_points.upper == 10'h161
		&& switch_points.lower == 10'h13F)
		else $error("points wrong at low reference");
	a_ref_high: assert property (@(posedge ref_clk)
		disable iff (rst) hysteresis_code == 3'h3 && avg_cmd == 10'h340
		&& dither_offset == 11'h7FB
		|=> switch_points.upper == 10'h358
		&& switch_points.lower == 10'h31E)
		else $error("points wrong at high reference");

	// overtemperature: drive off, flag set, no restart inside blanking
	a_trip_off: assert property (@(posedge ref_clk)
		disable iff (rst) ot_s |=> !lowside_drive_pin)
		else $error("drive not off in overtemp");
	a_trip_flag: assert property (@(posedge ref_clk)
		disable iff (rst) ot_s |=> fault_q)
		else $error("thermal fault not set");
	a_trip_quiet: assert property (@(posedge ref_clk)
		disable iff (rst) state_q == HSCC_TRIP |=> !lowside_drive_pin)
		else $error("drive on while tripped");
	a_trip_blank: assert property (@(posedge ref_clk)
		disable iff (rst) ot_s && state_q == HSCC_ON |=> blanking)
		else $error("no blanking after trip-out");
	a_trip_wait: assert property (@(posedge ref_clk)
		disable iff (rst) state_q == HSCC_TRIP && (ot_s || blanking)
		|=> state_q == HSCC_TRIP)
		else $error("left trip too early");
	a_fault_hold: assert property (@(posedge ref_clk)
		disable iff (rst) fault_q && !fault_reported |=> fault_q)
		else $error("thermal fault dropped");

	// blanking length and hold
	a_short_blank: assert property (@(posedge ref_clk)
		disable iff (rst) switch_now && slew_code < SLEW_LONG_MIN
		|=> blank_q == 8'h32)
		else $error("short blank length");
	a_long_blank: assert property (@(posedge ref_clk)
		disable iff (rst) switch_now && slew_code >= SLEW_LONG_MIN
		|=> blank_q == 8'h96)
		else $error("long blank length");
	a_blank_bound: assert property (@(posedge ref_clk)
		disable iff (rst) blank_q <= 8'h96)
		else $error("blank count out of range");
	a_blank_hold: assert property (@(posedge ref_clk)
		disable iff (rst) blanking && !ot_s |=> $stable(state_q))
		else $error("state changed while blanking");

	// switching on comparator events
	a_turn_off: assert property (@(posedge ref_clk)
		disable iff (rst) state_q == HSCC_ON && above_s && !blanking && !ot_s
		|=> s_state_off ##1 s_pin_low)
		else $error("no turn off at upper point");
	a_turn_on: assert property (@(posedge ref_clk)
		disable iff (rst) state_q == HSCC_OFF && below_s && !blanking && !ot_s
		|=> s_state_on)
		else $error("no turn on at lower point");
	a_off_quiet: assert property (@(posedge ref_clk)
		disable iff (rst) state_q == HSCC_OFF |=> s_pin_low)
		else $error("drive on while off");
endmodule : hscc_regulator

/* File: core/hscc_pkg.sv */
// constants and types for the hysteretic solenoid current regulator
package hscc_pkg;
	localparam int          CMD_W          = 10;
	localparam int          HYST_W         = 3;
	localparam int          SLEW_W         = 2;
	localparam int          DITH_W         = 11;
	localparam int          FULL_SCALE_MV  = 1230;
	localparam logic [CMD_W-1:0] CMD_MAX   = 10'h3FF;
	localparam logic [CMD_W-1:0] CMD_RESET = 10'h000;
	localparam logic [HYST_W-1:0] HYST_RESET = 3'h0;
	localparam logic [SLEW_W-1:0] SLEW_RESET = 2'h0;
	localparam logic [SLEW_W-1:0] SLEW_LONG_MIN = 2'h2;
	// hysteresis offsets in dac counts, codes 0..7
	localparam logic [5:0] HYST_CNT0 = 6'h11;
	localparam logic [5:0] HYST_CNT1 = 6'h15;
	localparam logic [5:0] HYST_CNT2 = 6'h19;
	localparam logic [5:0] HYST_CNT3 = 6'h1D;
	localparam logic [5:0] HYST_CNT4 = 6'h21;
	localparam logic [5:0] HYST_CNT5 = 6'h25;
	localparam logic [5:0] HYST_CNT6 = 6'h2A;
	localparam logic [5:0] HYST_CNT7 = 6'h2E;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          SHORT_BLANK_NS = 5000;
	localparam int          LONG_BLANK_NS  = 15000;
	localparam int          SHORT_BLANK_CYC = SHORT_BLANK_NS / CLK_PERIOD_NS;
	localparam int          LONG_BLANK_CYC  = LONG_BLANK_NS / CLK_PERIOD_NS;
	localparam int          BLANK_W        = 8;

	typedef struct packed {
		logic [CMD_W-1:0] upper;
		logic [CMD_W-1:0] lower;
	} hscc_points_t;
endpackage : hscc_pkg

/* File: core/hscc_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module hscc_sync (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dout <= 1'b0;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule : hscc_sync

/* File: tb/hscc_solenoid.sv */
// behavioural solenoid load with sense comparators
`timescale 1ns/100ps
module hscc_solenoid
	import hscc_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         lowside_drive_pin,
	input  wire hscc_points_t switch_points,
	output logic              above_upper_pin,
	output logic              below_lower_pin
);
	int cur = 0;
	// slow ramp, so blanking overshoot stays visible
	always @(posedge ref_clk) begin
		if (lowside_drive_pin)
			cur <= cur + 1;
		else if (cur > 0)
			cur <= cur - 1;
	end
	assign above_upper_pin = cur >= int'(switch_points.upper);
	assign below_lower_pin = cur <= int'(switch_points.lower);
endmodule : hscc_solenoid

/* File: tb/hscc_regulator_test.sv */
// self-checking bench for the hysteretic regulator
`timescale 1ns/100ps
module hscc_regulator_test
	import hscc_pkg::*;
;
	logic                     ref_clk = 0;
	logic                     rst = 1;
	logic                     overtemp_pin = 0;
	logic                     fault_reported = 0;
	logic [CMD_W-1:0]         avg_cmd = CMD_RESET;
	logic [HYST_W-1:0]        hysteresis_code = HYST_RESET;
	logic [SLEW_W-1:0]        slew_code = SLEW_RESET;
	logic signed [DITH_W-1:0] dither_offset = '0;
	logic                     above_upper_pin;
	logic                     below_lower_pin;
	logic                     lowside_drive_pin;
	logic                     thermal_fault;
	logic                     blanking;
	hscc_points_t             switch_points;
	logic [19:0]              exp_q[$];
	logic [5:0]               hc[8] = '{HYST_CNT0, HYST_CNT1, HYST_CNT2,
		HYST_CNT3, HYST_CNT4, HYST_CNT5, HYST_CNT6, HYST_CNT7};
	int                       bad_count = 0;
	int                       checks = 0;
	int                       seed = 89;
	int                       cyc = 0;
	int                       wait_cyc = 0;
	event                     seen;

	hscc_regulator i_hscc_regulator (.ref_clk(ref_clk), .rst(rst),
		.avg_cmd(avg_cmd), .hysteresis_code(hysteresis_code),
		.slew_code(slew_code), .dither_offset(dither_offset),
		.above_upper_pin(above_upper_pin), .below_lower_pin(below_lower_pin),
		.overtemp_pin(overtemp_pin), .fault_reported(fault_reported),
		.switch_points(switch_points), .lowside_drive_pin(lowside_drive_pin),
		.thermal_fault(thermal_fault), .blanking(blanking));
	hscc_solenoid i_hscc_solenoid (.ref_clk(ref_clk),
		.lowside_drive_pin(lowside_drive_pin), .switch_points(switch_points),
		.above_upper_pin(above_upper_pin), .below_lower_pin(below_lower_pin));

	always #50 ref_clk = ~ref_clk;

	task automatic check(input logic [19:0] sv, ev, input string what);
		checks++;
		if (sv !== ev) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, ev, sv);
		end
	endtask : check

	task automatic give_verdict();
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// dither kept small so the average itself never leaves the range
	task automatic points(input logic [9:0] c, input int h, d);
		int a;
		int u;
		int l;
		@(negedge ref_clk);
		avg_cmd = c;
		hysteresis_code = 3'(h);
		dither_offset = 11'(d);
		a = int'(c) + d;
		u = a + int'(hc[h]);
		l = a - int'(hc[h]);
		exp_q.push_back({10'(u > 1023 ? 1023 : u), 10'(l < 0 ? 0 : l)});
		@(negedge ref_clk);
		->seen;
	endtask : points

	always @(seen)
		check(switch_points, exp_q.pop_front(), "points");

	task automatic blank_len(input int s);
		int k;
		@(negedge ref_clk);
		slew_code = 2'(s);
		k = 0;
		while (blanking !== 1'b0)
			@(negedge ref_clk);
		while (blanking !== 1'b1)
			@(negedge ref_clk);
		while (blanking === 1'b1) begin
			k++;
			@(negedge ref_clk);
		end
		check(20'(k), 20'(s >= 2 ? LONG_BLANK_CYC : SHORT_BLANK_CYC), "blank");
	endtask : blank_len

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (4) @(negedge ref_clk);
		rst = 0;
		for (int i = 0; i < 8; i++)
			points(10'($random(seed)), i, 0);
		points(10'h200, 6, 0);
		points(CMD_MAX, 7, 0);
		points(10'h005, 7, 0);
		points(10'h14D, 0, 3);
		points(10'h340, 3, -5);
		points(10'h040, 0, 0);
		for (int s = 0; s < 4; s++)
			blank_len(s);
		// trip from the on state, so the drive really has to fall
		while (lowside_drive_pin !== 1'b1)
			@(negedge ref_clk);
		overtemp_pin = 1;
		repeat (6) @(negedge ref_clk);
		check(20'({lowside_drive_pin, thermal_fault}), 20'h0_0001, "trip");
		overtemp_pin = 0;
		repeat (8) @(negedge ref_clk);
		check(20'(thermal_fault), 20'h0_0001, "latch");
		fault_reported = 1;
		@(negedge ref_clk);
		fault_reported = 0;
		@(negedge ref_clk);
		check(20'(thermal_fault), 20'h0_0000, "release");
		wait_cyc = 0;
		while (lowside_drive_pin !== 1'b1
			&& wait_cyc < 2 * LONG_BLANK_CYC) begin
			wait_cyc++;
			@(negedge ref_clk);
		end
		check(20'(lowside_drive_pin), 20'h0_0001, "restart");
		give_verdict();
	end
endmodule : hscc_regulator_test
